// *** swr_pkg.sv ***
// constants and state types shared by the sleep wake-up and real-time counter block
package swr_pkg;

   // register bus geometry
   localparam int unsigned SWR_ADDR_W = 8;

   // register byte offsets
   localparam logic [7:0] SWR_OFF_WCNT = 8'h20; // wake_counter_value, read-only
   localparam logic [7:0] SWR_OFF_WCMP = 8'h24; // wake_compare_value, read/write
   localparam logic [7:0] SWR_OFF_RTC = 8'h28; // realtime_tick_value, read-only
   localparam logic [7:0] SWR_OFF_CTRL = 8'h40; // slow_crystal_control and enables
   localparam logic [7:0] SWR_OFF_STAT = 8'h44; // sticky event status, read-only
   localparam logic [7:0] SWR_OFF_CLR = 8'h48; // status clear, write-only
   localparam logic [7:0] SWR_OFF_IEN = 8'h4c; // interrupt enable

   // values after reset
   localparam logic [31:0] SWR_WORD_RST = 32'h0000_0000;
   localparam logic [3:0] SWR_CTRL_RST = 4'h0;
   localparam logic [1:0] SWR_EVT_RST = 2'h0;

   // control field positions
   localparam int unsigned SWR_CTRL_XSEL = 0; // slow_crystal_select: 1 picks the crystal
   localparam int unsigned SWR_CTRL_RING_EN = 1; // ring oscillator enabled
   localparam int unsigned SWR_CTRL_XTAL_EN = 2; // 32 kHz crystal enabled
   localparam int unsigned SWR_CTRL_TWAKE = 3; // timer wake enable

   // status field positions
   localparam int unsigned SWR_ST_HIB = 0; // hibernate_wake_event
   localparam int unsigned SWR_ST_DOZE = 1; // doze wake event

   // reference divider: one sleep tick every 128 reference cycles
   localparam int unsigned SWR_REF_DIV = 128;
   localparam logic [6:0] SWR_DIV_RST = 7'h00;
   localparam logic [6:0] SWR_DIV_LAST = 7'(SWR_REF_DIV - 1);

   // bus answers
   localparam logic [1:0] SWR_RESP_OKAY = 2'h0;
   localparam logic [1:0] SWR_RESP_SLVERR = 2'h2;
   localparam logic [3:0] SWR_STRB_FULL = 4'hf;

   // pin synchroniser state
   typedef struct packed {
      logic [2:0] sh;
      logic level;
      logic rise;
   } swr_sync_st_t;

   localparam swr_sync_st_t SWR_SYNC_RST = '{default: '0};

   // whole state of the counter block
   typedef struct packed {
      logic [31:0] wcnt;
      logic [31:0] wcmp;
      logic [31:0] rtc;
      logic [3:0] ctrl;
      logic [1:0] stat;
      logic [1:0] ien;
      logic [6:0] div;
      logic hib;
      logic doze;
      logic wake;
      logic irq;
      logic aw_have;
      logic [7:0] awa;
      logic w_have;
      logic [31:0] wd;
      logic [3:0] ws;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } swr_state_t;

   localparam swr_state_t SWR_STATE_RST = '{default: '0};

endpackage

// *** swr_sync_if.sv ***
// interface joining a raw oscillator pin to its synchroniser
`timescale 1ns/1ps
interface swr_sync_if;
   logic raw;
   logic level;
   logic rise;
   modport src (input raw, output level, output rise);
   modport dst (output raw, input level, input rise);
endinterface

// *** swr_pin_sync.sv ***
// three-flop pin synchroniser with rising-edge detection
`timescale 1ns/1ps
module swr_pin_sync
   import swr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   swr_sync_if.src port
);

   swr_sync_st_t s_q;
   swr_sync_st_t s_d;

   // shift the pin in; a change counts once flops two and three agree
   always_comb begin
      s_d = s_q;
      s_d.sh = {s_q.sh[1:0], port.raw};
      s_d.rise = 1'b0;
      if (s_q.sh[1] == s_q.sh[2] && s_q.sh[2] != s_q.level) begin
         s_d.level = s_q.sh[2];
         s_d.rise = s_q.sh[2];
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= SWR_SYNC_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign port.level = s_q.level;
   assign port.rise = s_q.rise;

   // an edge is reported only after two agreeing high samples
   property p_rise_agreed;
      @(posedge aclk) disable iff (!aresetn)
      port.rise |-> $past(s_q.sh[1]) && $past(s_q.sh[2]) && !$past(s_q.level);
   endproperty
   a_rise_agreed: assert property (p_rise_agreed) else $error("edge without agreement");

endmodule

// *** swr_sleep_rtc.sv ***
// sleep wake-up timer and real-time counter with AXI4-Lite registers
// What this block does
// - each hibernate or doze entry clears wake count, then it counts sleep ticks
// - live wake count reads at 0x20, read-only, full 32-bit words
// - wake clock is ring oscillator, 32 kHz crystal, or reference over 128
// - doze counts reference over 128; hibernate counts ring or crystal
// - 32-bit read/write wake compare register, reset zero, sets sleep length
// - wake count keeps running past the compare while the processor restarts
// - real-time count is 32-bit, starts at zero and wraps past all ones
// - real-time count reads at 0x28; writes never alter it
// - real-time count advances only while its selected oscillator is enabled
// - switching real-time clock source needs no compensation; counting continues
// - real-time count and compare keep values through sleep; reads are whole words
// - hibernate wake with timer wake enabled sets sticky status, write one clears
`timescale 1ns/1ps
module swr_sleep_rtc
   import swr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [SWR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [SWR_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ring_osc_pin,
   input wire logic slow_crystal_pin,
   input wire logic hibernate_active,
   input wire logic doze_active,
   output logic wake_request,
   output logic irq
);

   swr_state_t s_q;
   swr_state_t s_d;

   swr_sync_if ring_if ();
   swr_sync_if xtal_if ();

   logic ring_tick;
   logic xtal_tick;
   logic slow_tick;
   logic ref_tick;
   logic sleep_now;
   logic entry;
   logic wtick;
   logic hit;
   logic hib_exit;
   logic doze_exit;
   logic [7:0] wr_addr;
   logic [7:0] rd_addr;
   logic [31:0] rd_word;
   logic rd_ok;

   // oscillator pins cross into the bus clock through three flops
   assign ring_if.raw = ring_osc_pin;
   assign xtal_if.raw = slow_crystal_pin;

   swr_pin_sync u_ring_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .port(ring_if.src)
   );

   swr_pin_sync u_xtal_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .port(xtal_if.src)
   );

   // tick sources: an oscillator edge counts only while that oscillator is on
   assign ring_tick = ring_if.rise & s_q.ctrl[SWR_CTRL_RING_EN];
   assign xtal_tick = xtal_if.rise & s_q.ctrl[SWR_CTRL_XTAL_EN];
   assign slow_tick = s_q.ctrl[SWR_CTRL_XSEL] ? xtal_tick : ring_tick;
   assign ref_tick = (s_q.div == SWR_DIV_LAST);

   // sleep tracking; hibernate wins if both levels are up
   assign sleep_now = hibernate_active | doze_active;
   assign entry = sleep_now & ~(s_q.hib | s_q.doze);
   assign wtick = hibernate_active ? slow_tick : ref_tick;
   assign hib_exit = s_q.hib & ~hibernate_active & s_q.ctrl[SWR_CTRL_TWAKE];
   assign doze_exit = s_q.doze & ~doze_active & s_q.ctrl[SWR_CTRL_TWAKE];

   // compare hit: on entry for a zero compare, else when the next count lands on it
   assign hit = (entry && s_q.wcmp == SWR_WORD_RST) ||
                (!entry && sleep_now && wtick &&
                 32'(s_q.wcnt + 32'h0000_0001) == s_q.wcmp);

   // word-aligned addresses of the pending accesses
   assign wr_addr = {s_q.awa[7:2], 2'h0};
   assign rd_addr = {s_axi_araddr[7:2], 2'h0};

   // read mux: one capture of a whole word gives a coherent value
   always_comb begin
      rd_word = SWR_WORD_RST;
      rd_ok = 1'b1;
      case (rd_addr)
         SWR_OFF_WCNT: rd_word = s_q.wcnt;
         SWR_OFF_WCMP: rd_word = s_q.wcmp;
         SWR_OFF_RTC: rd_word = s_q.rtc;
         SWR_OFF_CTRL: rd_word = {28'h0, s_q.ctrl};
         SWR_OFF_STAT: rd_word = {30'h0, s_q.stat};
         SWR_OFF_CLR: rd_word = SWR_WORD_RST;
         SWR_OFF_IEN: rd_word = {30'h0, s_q.ien};
         default: rd_ok = 1'b0;
      endcase
   end

   // next-state logic for counters, registers and bus handshakes
   always_comb begin
      s_d = s_q;
      s_d.hib = hibernate_active;
      s_d.doze = doze_active;
      s_d.div = s_q.div + 7'h01;

      // wake counter: cleared on entry, counts only while asleep, held otherwise
      if (entry) begin
         s_d.wcnt = SWR_WORD_RST;
      end else if (sleep_now && wtick) begin
         s_d.wcnt = 32'(s_q.wcnt + 32'h0000_0001);
      end
      s_d.wake = hit;

      // real-time counter: free running, wraps, never written by software
      if (slow_tick) begin
         s_d.rtc = 32'(s_q.rtc + 32'h0000_0001);
      end

      // take write address and data independently
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wd = s_axi_wdata;
         s_d.ws = s_axi_wstrb;
      end

      // perform a write once both halves are held
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = SWR_RESP_OKAY;
         case (wr_addr)
            SWR_OFF_WCMP: begin
               if (s_q.ws == SWR_STRB_FULL) begin
                  s_d.wcmp = s_q.wd;
               end else begin
                  s_d.bresp = SWR_RESP_SLVERR;
               end
            end
            SWR_OFF_CTRL: begin
               if (s_q.ws[0]) begin
                  s_d.ctrl = s_q.wd[3:0];
               end
            end
            SWR_OFF_CLR: begin
               if (s_q.ws[0]) begin
                  s_d.stat = s_q.stat & ~s_q.wd[1:0];
               end
            end
            SWR_OFF_IEN: begin
               if (s_q.ws[0]) begin
                  s_d.ien = s_q.wd[1:0];
               end
            end
            SWR_OFF_WCNT, SWR_OFF_RTC, SWR_OFF_STAT: begin
               s_d.bresp = SWR_RESP_OKAY; // read-only, write ignored
            end
            default: s_d.bresp = SWR_RESP_SLVERR;
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      // events set after the clear so a same-cycle event survives
      if (hib_exit) begin
         s_d.stat[SWR_ST_HIB] = 1'b1;
      end
      if (doze_exit) begin
         s_d.stat[SWR_ST_DOZE] = 1'b1;
      end

      // read channel: answer one cycle after the address is taken
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_word;
         s_d.rresp = rd_ok ? SWR_RESP_OKAY : SWR_RESP_SLVERR;
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end

      // ready flags follow the holding state
      s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
      s_d.wready = ~s_d.w_have & ~s_d.bvalid;
      s_d.arready = ~s_d.rvalid;
      s_d.irq = |(s_d.stat & s_d.ien);
   end

   // state register; a hardware reset zeroes the counters, and sleep entry also clears the wake count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= SWR_STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign wake_request = s_q.wake;
   assign irq = s_q.irq;

   // checks on counter and register behaviour
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_entry;
      !(s_q.hib || s_q.doze) ##0 (hibernate_active || doze_active);
   endsequence

   sequence s_cmp_write;
      s_q.aw_have && s_q.w_have && !s_q.bvalid ##0
      wr_addr == SWR_OFF_WCMP && s_q.ws == SWR_STRB_FULL;
   endsequence

   sequence s_hib_leave;
      s_q.hib && s_q.ctrl[SWR_CTRL_TWAKE] ##0 !hibernate_active;
   endsequence

   property p_entry_clear;
      s_entry |=> s_q.wcnt == 32'h0000_0000;
   endproperty
   a_entry_clear: assert property (p_entry_clear) else $error("entry did not clear");

   property p_hib_source;
      hibernate_active && !entry && s_q.ctrl[SWR_CTRL_XSEL] && xtal_tick
      |=> s_q.wcnt == $past(s_q.wcnt) + 32'h0000_0001;
   endproperty
   a_hib_source: assert property (p_hib_source) else $error("crystal tick missed");

   property p_doze_source;
      doze_active && !hibernate_active && !entry
      |=> s_q.wcnt == $past(s_q.wcnt) + {31'h0, $past(ref_tick)};
   endproperty
   a_doze_source: assert property (p_doze_source) else $error("doze step wrong");

   property p_cmp_write;
      s_cmp_write |=> s_q.wcmp == $past(s_q.wd) && s_q.bvalid && s_q.bresp == SWR_RESP_OKAY;
   endproperty
   a_cmp_write: assert property (p_cmp_write) else $error("compare not written");

   property p_run_past;
      sleep_now && !entry && wtick && s_q.wcnt == s_q.wcmp
      |=> s_q.wcnt == $past(s_q.wcmp) + 32'h0000_0001;
   endproperty
   a_run_past: assert property (p_run_past) else $error("count stopped at compare");

   property p_rtc_step;
      slow_tick |=> s_q.rtc == $past(s_q.rtc) + 32'h0000_0001;
   endproperty
   a_rtc_step: assert property (p_rtc_step) else $error("real-time step wrong");

   property p_rtc_hold;
      !slow_tick |=> $stable(s_q.rtc);
   endproperty
   a_rtc_hold: assert property (p_rtc_hold) else $error("real-time count disturbed");

   property p_rtc_off;
      !s_q.ctrl[SWR_CTRL_RING_EN] && !s_q.ctrl[SWR_CTRL_XTAL_EN] |=> $stable(s_q.rtc);
   endproperty
   a_rtc_off: assert property (p_rtc_off) else $error("count with oscillator off");

   property p_keep_awake;
      !sleep_now |=> $stable(s_q.wcnt);
   endproperty
   a_keep_awake: assert property (p_keep_awake) else $error("wake count lost");

   property p_hib_flag;
      s_hib_leave |=> s_q.stat[SWR_ST_HIB] ##1 s_q.stat[SWR_ST_HIB] || $past(s_q.aw_have);
   endproperty
   a_hib_flag: assert property (p_hib_flag) else $error("hibernate flag not set");

   // a wake request only shows while asleep with the count on the compare
   property p_wake_pulse;
      wake_request |-> s_q.wcnt == s_q.wcmp && (s_q.hib || s_q.doze);
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake request mistimed");

   property p_irq_level;
      irq == |(s_q.stat & s_q.ien);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

   // interrupt rises only after a wake event or an enable write
   property p_irq_rise;
      $rose(irq) |-> $past(hib_exit || doze_exit || (s_q.aw_have && s_q.w_have &&
                                                   !s_q.bvalid && wr_addr == SWR_OFF_IEN));
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");

   // status stays set until a clear write reaches it; reads leave it alone
   property p_stat_sticky;
      s_q.stat[SWR_ST_HIB] && !(s_q.aw_have && s_q.w_have && !s_q.bvalid &&
                                 wr_addr == SWR_OFF_CLR)
      |=> s_q.stat[SWR_ST_HIB];
   endproperty
   a_stat_sticky: assert property (p_stat_sticky) else $error("status lost");

   // a compare write with a partial strobe changes nothing and is refused
   property p_cmp_partial;
      s_q.aw_have && s_q.w_have && !s_q.bvalid && wr_addr == SWR_OFF_WCMP &&
      s_q.ws != SWR_STRB_FULL |=> $stable(s_q.wcmp) && s_q.bresp == SWR_RESP_SLVERR;
   endproperty
   a_cmp_partial: assert property (p_cmp_partial) else $error("partial compare write");

   // a zero compare wakes at once on entry
   property p_zero_cmp;
      s_entry ##0 s_q.wcmp == 32'h0000_0000 |=> wake_request;
   endproperty
   a_zero_cmp: assert property (p_zero_cmp) else $error("zero compare missed");

   // a taken read address is answered on the next cycle
   property p_read_answer;
      s_axi_arvalid && s_q.arready |=> s_q.rvalid && !s_q.arready;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");

endmodule

// *** swr_tb.sv ***
// self-checking bench for the sleep wake-up and real-time counter block
`timescale 1ns/1ps
module tb;
   import swr_pkg::*;
   logic aclk;
   logic aresetn;
   logic [SWR_ADDR_W-1:0] awaddr;
   logic [SWR_ADDR_W-1:0] araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, wake_request, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic ring, xtal, hib, doze;
   int fails, n_checks, wakes, w0;
   logic [31:0] v, base;

   swr_sleep_rtc u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ring_osc_pin(ring),
      .slow_crystal_pin(xtal), .hibernate_active(hib), .doze_active(doze),
      .wake_request(wake_request), .irq(irq)
   );

   // 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // count wake pulses
   always @(posedge aclk) begin
      if (wake_request === 1'b1) wakes <= wakes + 1;
   end

   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask

   task automatic tmo(input string nm);
      $display("ERROR %s expected answer seen timeout", nm);
      fails++;
      results();
   endtask

   // one write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      int i;
      bit ad, dd;
      ad = 0;
      dd = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; !(ad && dd); i++) begin
         if (i > 50) tmo("write accept");
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!dd && wready === 1'b1) begin
            dd = 1;
            wvalid <= 1'b0;
         end
      end
      for (i = 0; bvalid !== 1'b1; i++) begin
         if (i > 50) tmo("write answer");
         @(posedge aclk);
      end
      chk("write response", {30'h0, er}, {30'h0, bresp});
      bready <= 1'b0;
   endtask

   // one read, rready held until the answer is sampled
   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      int i;
      bit got;
      got = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; !got; i++) begin
         if (i > 50) tmo("read answer");
         @(posedge aclk);
         if (rvalid === 1'b1) got = 1;
         if (arready === 1'b1) arvalid <= 1'b0;
      end
      d = rdata;
      chk("read response", {30'h0, er}, {30'h0, rresp});
      rready <= 1'b0;
   endtask

   // slow pin pulses, long enough for the synchroniser to see each edge
   task automatic pulse(input bit sel, input int n);
      repeat (n) begin
         if (sel) xtal <= 1'b1;
         else ring <= 1'b1;
         repeat (6) @(posedge aclk);
         ring <= 1'b0;
         xtal <= 1'b0;
         repeat (6) @(posedge aclk);
      end
   endtask

   // main sequence
   initial begin
      aresetn = 1'b0;
      awaddr = '0;
      araddr = '0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      wdata = '0;
      wstrb = '0;
      ring = 1'b0;
      xtal = 1'b0;
      hib = 1'b0;
      doze = 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(SWR_OFF_WCNT, SWR_RESP_OKAY, v);
      chk("wake count reset", SWR_WORD_RST, v);
      rd(SWR_OFF_WCMP, SWR_RESP_OKAY, v);
      chk("compare reset", SWR_WORD_RST, v);
      rd(SWR_OFF_RTC, SWR_RESP_OKAY, v);
      chk("rtc reset", SWR_WORD_RST, v);
      rd(8'h10, SWR_RESP_SLVERR, v);
      chk("unmapped read", 32'h0, v);
      $display("test reset values done");
      // compare access, partial write refused, read-only counts ignore writes
      wr(SWR_OFF_WCMP, 32'ha5a5_5a5a, SWR_STRB_FULL, SWR_RESP_OKAY);
      wr(SWR_OFF_WCMP, 32'h1234_5678, 4'h3, SWR_RESP_SLVERR);
      rd(SWR_OFF_WCMP, SWR_RESP_OKAY, v);
      chk("compare value", 32'ha5a5_5a5a, v);
      wr(SWR_OFF_RTC, 32'hffff_ffff, SWR_STRB_FULL, SWR_RESP_OKAY);
      wr(SWR_OFF_WCNT, 32'hffff_ffff, SWR_STRB_FULL, SWR_RESP_OKAY);
      pulse(0, 2);
      rd(SWR_OFF_RTC, SWR_RESP_OKAY, v);
      chk("rtc with oscillators off", 32'h0, v);
      rd(SWR_OFF_WCNT, SWR_RESP_OKAY, v);
      chk("wake count after write", 32'h0, v);
      $display("test register access done");
      // hibernate on the ring oscillator with timer wake enabled
      wr(SWR_OFF_CTRL, 32'h0000_000a, SWR_STRB_FULL, SWR_RESP_OKAY);
      wr(SWR_OFF_IEN, 32'h0000_0003, SWR_STRB_FULL, SWR_RESP_OKAY);
      wr(SWR_OFF_WCMP, 32'h0000_0003, SWR_STRB_FULL, SWR_RESP_OKAY);
      pulse(0, 2);
      rd(SWR_OFF_RTC, SWR_RESP_OKAY, v);
      chk("rtc on ring", 32'h2, v);
      w0 = wakes;
      hib <= 1'b1;
      repeat (3) @(posedge aclk);
      pulse(0, 5);
      chk("hibernate wake pulses", 32'h1, 32'(wakes - w0));
      hib <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("irq after hibernate", 32'h1, {31'h0, irq});
      rd(SWR_OFF_STAT, SWR_RESP_OKAY, v);
      chk("hibernate status", 32'h1, v);
      chk("irq after status read", 32'h1, {31'h0, irq});
      rd(SWR_OFF_WCNT, SWR_RESP_OKAY, v);
      chk("wake count past compare", 32'h5, v);
      rd(SWR_OFF_RTC, SWR_RESP_OKAY, v);
      chk("rtc through hibernate", 32'h7, v);
      wr(SWR_OFF_CLR, 32'h0000_0001, SWR_STRB_FULL, SWR_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq after clear", 32'h0, {31'h0, irq});
      rd(SWR_OFF_STAT, SWR_RESP_OKAY, v);
      chk("status after clear", 32'h0, v);
      $display("test hibernate done");
      // doze on the reference divider, count restarts from zero
      wr(SWR_OFF_WCMP, 32'h0000_0002, SWR_STRB_FULL, SWR_RESP_OKAY);
      w0 = wakes;
      doze <= 1'b1;
      for (int i = 0; wakes == w0; i++) begin
         if (i > 600) tmo("doze wake");
         @(posedge aclk);
      end
      doze <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(SWR_OFF_WCNT, SWR_RESP_OKAY, v);
      chk("doze wake count", 32'h2, v);
      rd(SWR_OFF_STAT, SWR_RESP_OKAY, v);
      chk("doze status", 32'h2, v);
      wr(SWR_OFF_IEN, 32'h0000_0001, SWR_STRB_FULL, SWR_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("masked irq", 32'h0, {31'h0, irq});
      wr(SWR_OFF_CLR, 32'h0000_0002, SWR_STRB_FULL, SWR_RESP_OKAY);
      repeat (300) @(posedge aclk);
      rd(SWR_OFF_WCNT, SWR_RESP_OKAY, v);
      chk("wake count held awake", 32'h2, v);
      $display("test doze done");
      // crystal source for both counts, ring ignored when not selected
      rd(SWR_OFF_RTC, SWR_RESP_OKAY, base);
      wr(SWR_OFF_CTRL, 32'h0000_0005, SWR_STRB_FULL, SWR_RESP_OKAY);
      pulse(1, 3);
      pulse(0, 2);
      rd(SWR_OFF_RTC, SWR_RESP_OKAY, v);
      chk("rtc on crystal", base + 32'h3, v);
      wr(SWR_OFF_WCMP, 32'h0000_0000, SWR_STRB_FULL, SWR_RESP_OKAY);
      w0 = wakes;
      hib <= 1'b1;
      repeat (3) @(posedge aclk);
      pulse(1, 2);
      hib <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(SWR_OFF_WCNT, SWR_RESP_OKAY, v);
      chk("wake count on crystal", 32'h2, v);
      chk("zero compare wake", 32'h1, 32'(wakes - w0));
      rd(SWR_OFF_STAT, SWR_RESP_OKAY, v);
      chk("status with timer wake off", 32'h0, v);
      $display("test crystal done");
      results();
   end
endmodule
